// >>> rtl/interrupt_vector_and_trap_unit.sv
// Purpose: Node control, arbitration, vector generation and hardware trap entry.
// Assumes: Requests, trap events and core handshakes come from logic on sys_clk.
// Notes: The service offer is registered; after each accept one idle cycle follows.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`include "ivt_cfg.svh"
module interrupt_vector_and_trap_unit #(
	parameter int NUM_NODES = `NUM_NODES,
	parameter int NUM_HW = `NUM_HW_NODES
)(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [NUM_NODES-1:0] periph_req,
	input wire logic [`NUM_TRAPS-1:0] trap_evt,
	output ivt_pkg::svc_req_t svc_out,
	output logic svc_valid,
	input wire logic svc_ack,
	input wire logic int_ret,
	input wire logic trap_ret,
	output logic [`PRIO_W-1:0] cpu_level,
	output logic trap_busy,
	output logic irq
);
	import ivt_pkg::*;

	generate
		if (NUM_NODES > `NUM_NODES || NUM_NODES < 1 || NUM_HW > NUM_NODES)
		begin : g_chk
			$error("interrupt_vector_and_trap_unit: node counts out of range");
		end
	endgenerate

	localparam logic [`NUM_NODES*7-1:0] TRAP_TABLE = `NODE_TRAP_TABLE;

	function automatic logic [6:0] node_trap(input logic [5:0] idx);
		node_trap = TRAP_TABLE[(`NUM_NODES - 1 - int'(idx)) * 7 +: 7];
	endfunction

	function automatic logic [`PRIO_W-1:0] top_level(input logic [15:0] v);
		top_level = '0;
		for (int i = 1; i < 16; i++)
		begin
			if (v[i])
				top_level = `PRIO_W'(i);
		end
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	node_ctrl_t node_r [NUM_NODES];
	logic [`VEC_SEG_W-1:0] vec_seg_r;
	logic [`SPACING_W-1:0] spacing_r;
	logic [`NUM_TRAPS-1:0] trap_flag_r;
	logic [`NUM_TRAPS-1:0] trap_pend_r;
	logic [`NUM_EVENTS-1:0] irq_stat_r;
	logic [`NUM_EVENTS-1:0] irq_mask_r;
	logic [15:0] in_svc_r;
	logic active_a_r;
	logic active_b_r;
	svc_req_t svc_r;
	logic svc_valid_r;
	logic [31:0] rdata_r;
	logic [31:0] rd_word;

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	wire wr_seg = reg_wr && reg_addr == `VEC_SEG_OFS;
	wire wr_cfg = reg_wr && reg_addr == `CORE_CFG_OFS;
	wire wr_tfr = reg_wr && reg_addr == `TRAP_FLAG_OFS;
	wire wr_ist = reg_wr && reg_addr == `IRQ_STAT_OFS;
	wire wr_msk = reg_wr && reg_addr == `IRQ_MASK_OFS;
	wire [`ADDR_W-1:0] node_rel = reg_addr - `NODE_BASE_OFS;
	wire [5:0] node_sel = node_rel[7:2];
	wire node_hit = reg_addr >= `NODE_BASE_OFS && node_rel[1:0] == 2'b00 &&
		int'(node_rel[`ADDR_W-1:2]) < NUM_NODES;

	// ----------------------------------------
	// Node control registers
	// ----------------------------------------
	logic [NUM_NODES-1:0] pend;
	logic [NUM_NODES*`PRIO_W-1:0] prio_flat;
	wire ack_node = svc_ack && svc_valid_r && !svc_r.is_trap;
	wire ack_trap = svc_ack && svc_valid_r && svc_r.is_trap;

	genvar g;
	generate
		for (g = 0; g < NUM_NODES; g++)
		begin : g_node
			wire hw_set = (g < NUM_HW) && periph_req[g];
			wire wr_hit = reg_wr && node_hit && int'(node_sel) == g;
			wire clr = ack_node && int'(svc_r.src) == g;
			node_ctrl_t base;
			node_ctrl_t node_nxt;
			assign base = wr_hit ? node_ctrl_t'(reg_wdata[7:0]) : node_r[g];
			assign node_nxt = '{req: hw_set | (base.req & ~clr), en: base.en,
				spare: 2'b00, prio: base.prio};
			assign pend[g] = node_r[g].req && node_r[g].en;
			assign prio_flat[g*`PRIO_W +: `PRIO_W] = node_r[g].prio;
			always_ff @(posedge sys_clk)
			begin
				if (sys_rst)
					node_r[g] <= '0;
				else
					node_r[g] <= node_nxt;
			end
		end
	endgenerate

	logic win_valid;
	logic [5:0] win_idx;
	logic [`PRIO_W-1:0] win_prio;

	prio_arbiter #(
		.N(NUM_NODES),
		.LW(`PRIO_W)
	) u_arb (
		.pend(pend),
		.prio(prio_flat),
		.win_valid(win_valid),
		.win_idx(win_idx),
		.win_prio(win_prio)
	);

	// ----------------------------------------
	// Trap selection
	// ----------------------------------------
	wire [3:0] a_pend = 4'(trap_pend_r & `TRAP_A_MASK);
	wire [`NUM_TRAPS-1:0] b_pend = trap_pend_r & `TRAP_B_MASK;
	wire [1:0] a_idx = a_pend[0] ? 2'd0 : a_pend[1] ? 2'd1 : a_pend[2] ? 2'd2 : 2'd3;
	// class A preempts B; waits only for class A
	wire a_hit = |a_pend && !active_a_r;
	wire b_hit = |b_pend && !active_a_r && !active_b_r;
	assign trap_busy = active_a_r || active_b_r;
	assign cpu_level = top_level(in_svc_r);
	// node only above level, never under a trap
	wire int_ok = win_valid && win_prio > cpu_level && !trap_busy;

	// ----------------------------------------
	// Vector formation
	// ----------------------------------------
	// traps win over every node request
	wire cand_trap_sel = a_hit || b_hit;
	wire [6:0] a_trap = `TRAP_A_FIRST + 7'(`TRAP_A_STEP * int'(a_idx));
	wire [6:0] cand_num = a_hit ? a_trap : b_hit ? `TRAP_B_NUM : node_trap(win_idx);
	// step is four bytes shifted by the spacing field
	wire [2:0] vec_shift = `VEC_STEP_SHIFT + 3'(spacing_r);
	wire [15:0] cand_ofs = 16'({9'h000, cand_num}) << vec_shift;
	svc_req_t cand;
	assign cand = '{vec: {vec_seg_r, cand_ofs}, trap: cand_num, is_trap: cand_trap_sel,
		level: cand_trap_sel ? 4'hf : win_prio,
		src: a_hit ? {4'h0, a_idx} : b_hit ? 6'h04 : win_idx};
	wire cand_valid = cand_trap_sel || int_ok;

	// ----------------------------------------
	// Service offer and nesting state
	// ----------------------------------------
	wire [15:0] lvl_bit = 16'h0001 << svc_r.level;
	wire [15:0] top_bit = 16'h0001 << cpu_level;
	wire [15:0] in_svc_nxt = (in_svc_r & ~(int_ret ? top_bit : 16'h0000)) |
		(ack_node ? lvl_bit : 16'h0000);
	wire a_ack = ack_trap && svc_r.trap != `TRAP_B_NUM;
	wire b_ack = ack_trap && svc_r.trap == `TRAP_B_NUM;
	wire [`NUM_TRAPS-1:0] a_clr = a_ack ? `NUM_TRAPS'(8'h01 << svc_r.src[1:0]) : 8'h00;
	wire [`NUM_TRAPS-1:0] trap_clr = a_clr | (b_ack ? `TRAP_B_MASK : 8'h00);
	// per-trap flag, set wins over clear
	wire [`NUM_TRAPS-1:0] flag_clr = wr_tfr ? reg_wdata[`NUM_TRAPS-1:0] : 8'h00;
	wire [`NUM_EVENTS-1:0] ev = {ack_node, |trap_evt};
	wire [`NUM_EVENTS-1:0] ist_clr = wr_ist ? reg_wdata[`NUM_EVENTS-1:0] : 2'b00;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			vec_seg_r <= `VEC_SEG_RST;
			spacing_r <= `SPACING_RST;
			trap_flag_r <= '0;
			trap_pend_r <= '0;
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			in_svc_r <= '0;
			active_a_r <= 1'b0;
			active_b_r <= 1'b0;
			svc_r <= '0;
			svc_valid_r <= 1'b0;
			rdata_r <= '0;
		end
		else
		begin
			if (wr_seg)
				vec_seg_r <= reg_wdata[`VEC_SEG_W-1:0];
			if (wr_cfg)
				spacing_r <= reg_wdata[`SPACING_LSB +: `SPACING_W];
			if (wr_msk)
				irq_mask_r <= reg_wdata[`NUM_EVENTS-1:0];
			trap_flag_r <= trap_evt | (trap_flag_r & ~flag_clr);
			trap_pend_r <= trap_evt | (trap_pend_r & ~trap_clr);
			irq_stat_r <= ev | (irq_stat_r & ~ist_clr);
			in_svc_r <= in_svc_nxt;
			active_a_r <= a_ack || (active_a_r && !trap_ret);
			active_b_r <= b_ack || (active_b_r && !(trap_ret && !active_a_r));
			svc_r <= cand;
			svc_valid_r <= cand_valid && !svc_ack;
			rdata_r <= reg_rd ? rd_word : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Read data and outputs
	// ----------------------------------------
	assign rd_word =
		reg_addr == `VEC_SEG_OFS ? 32'(vec_seg_r) :
		reg_addr == `CORE_CFG_OFS ? 32'(spacing_r) << `SPACING_LSB :
		reg_addr == `TRAP_FLAG_OFS ? 32'(trap_flag_r) :
		reg_addr == `IRQ_STAT_OFS ? 32'(irq_stat_r) :
		reg_addr == `IRQ_MASK_OFS ? 32'(irq_mask_r) :
		reg_addr == `LEVEL_OFS ? {23'h000000, active_b_r, active_a_r, 3'h0, cpu_level} :
		node_hit ? 32'(node_r[node_sel]) : 32'h0000_0000;

	assign reg_rdata = rdata_r;
	assign svc_out = svc_r;
	assign svc_valid = svc_valid_r;
	assign irq = |(irq_stat_r & irq_mask_r);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	property p_vec_default;
		svc_valid && $past(spacing_r) == 2'b00 |-> svc_out.vec[15:0] == 16'(svc_out.trap) * 16'd4;
	endproperty
	a_vec_default: assert property (p_vec_default) else $error("vector step not four");

	property p_vec_seg;
		svc_valid && $stable(vec_seg_r) |-> svc_out.vec[23:16] == vec_seg_r;
	endproperty
	a_vec_seg: assert property (p_vec_seg) else $error("vector segment mismatch");

	property p_vec_spacing;
		svc_valid && $stable(spacing_r) |->
			svc_out.vec[15:0] == 16'({9'h000, svc_out.trap}) << (3'd2 + 3'(spacing_r));
	endproperty
	a_vec_spacing: assert property (p_vec_spacing) else $error("spacing not applied");

	property p_rtc_vec;
		svc_valid && !svc_out.is_trap && svc_out.src == 6'(`NODE_RTC_IDX) |->
			svc_out.trap == 7'h5d;
	endproperty
	a_rtc_vec: assert property (p_rtc_vec) else $error("clock node trap wrong");

	property p_eop_vec;
		svc_valid && !svc_out.is_trap && svc_out.src == 6'(`NODE_EOP_IDX) &&
			$past(spacing_r) == 2'b00 |-> svc_out.trap == 7'h4c && svc_out.vec[15:0] == 16'h0130;
	endproperty
	a_eop_vec: assert property (p_eop_vec) else $error("transfer end vector wrong");

	property p_trap_entry;
		(trap_evt != 8'h00 && !trap_busy && !svc_ack) ##1 !svc_ack |=>
			svc_valid && svc_out.is_trap;
	endproperty
	a_trap_entry: assert property (p_trap_entry) else $error("trap not offered");

	property p_trap_flag;
		trap_evt != 8'h00 |=> (trap_flag_r & $past(trap_evt)) == $past(trap_evt);
	endproperty
	a_trap_flag: assert property (p_trap_flag) else $error("trap flag not set");

	property p_trap_blocks;
		trap_busy && $past(trap_busy) |-> !(svc_valid && !svc_out.is_trap);
	endproperty
	a_trap_blocks: assert property (p_trap_blocks) else $error("node offered in trap");

	property p_higher;
		svc_valid && !svc_out.is_trap |-> svc_out.level > cpu_level;
	endproperty
	a_higher: assert property (p_higher) else $error("node not above level");

endmodule

// >>> rtl/ivt_cfg.svh
// Purpose: Offsets, field positions, reset values and vector numbers of the vector and trap unit.
// Assumes: Byte addresses on a 12-bit register port with 32-bit data.
// Notes: Definitions only.
`ifndef IVT_CFG_SVH
`define IVT_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define VEC_SEG_OFS 12'h000
`define CORE_CFG_OFS 12'h004
`define TRAP_FLAG_OFS 12'h008
`define IRQ_STAT_OFS 12'h00c
`define IRQ_MASK_OFS 12'h010
`define LEVEL_OFS 12'h014
`define NODE_BASE_OFS 12'h100
`define ADDR_W 12

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define VEC_SEG_W 8
`define VEC_SEG_RST 8'h00
`define SPACING_LSB 0
`define SPACING_W 2
`define SPACING_RST 2'b00
`define VEC_STEP_SHIFT 3'd2
`define PRIO_W 4
`define NUM_EVENTS 2
`define EV_TRAP 0
`define EV_ACCEPT 1

// ----------------------------------------
// Traps and nodes
// ----------------------------------------
`define NUM_TRAPS 8
`define TRAP_A_MASK 8'h0f
`define TRAP_B_MASK 8'hf0
`define TRAP_A_FIRST 7'h02
`define TRAP_A_STEP 2
`define TRAP_B_NUM 7'h0a
`define NUM_NODES 51
`define NUM_HW_NODES 28
`define NODE_EOP_IDX 15
`define NODE_RTC_IDX 27
`define NODE_TRAP_TABLE { \
	7'h27, 7'h2a, 7'h47, 7'h2b, 7'h2c, 7'h5f, 7'h2d, 7'h2e, 7'h2f, 7'h43, \
	7'h48, 7'h5e, 7'h49, 7'h4a, 7'h42, 7'h4c, 7'h51, 7'h52, 7'h53, 7'h54, \
	7'h55, 7'h56, 7'h57, 7'h59, 7'h5a, 7'h5b, 7'h5c, 7'h5d, \
	7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h1e, 7'h1f, \
	7'h20, 7'h21, 7'h28, 7'h29, 7'h3f, 7'h40, 7'h41, 7'h4b, 7'h4d, 7'h4e, \
	7'h4f, 7'h50, 7'h58}

`endif

// >>> rtl/ivt_pkg.sv
// Purpose: Types shared by the vector and trap unit.
// Assumes: Nothing.
// Notes: Node control layout is req, enable, two spare bits, priority.
package ivt_pkg;

	typedef struct packed {
		logic req;
		logic en;
		logic [1:0] spare;
		logic [3:0] prio;
	} node_ctrl_t;

	typedef struct packed {
		logic [23:0] vec;
		logic [6:0] trap;
		logic is_trap;
		logic [3:0] level;
		logic [5:0] src;
	} svc_req_t;

endpackage

// >>> rtl/prio_arbiter.sv
// Purpose: Picks the pending node with the highest priority level.
// Assumes: Levels are unsigned; ties go to the lowest index.
// Notes: Purely combinational.
`timescale 1ns/100ps
module prio_arbiter #(
	parameter int N = 51,
	parameter int LW = 4
)(
	input wire logic [N-1:0] pend,
	input wire logic [N*LW-1:0] prio,
	output logic win_valid,
	output logic [5:0] win_idx,
	output logic [LW-1:0] win_prio
);

	generate
		if (N > 64 || N < 1)
		begin : g_chk
			$error("prio_arbiter: N must lie in 1..64");
		end
	endgenerate

	always_comb
	begin
		win_valid = 1'b0;
		win_idx = 6'h00;
		win_prio = '0;
		for (int i = 0; i < N; i++)
		begin
			if (pend[i] && (!win_valid || prio[i*LW +: LW] > win_prio))
			begin
				win_valid = 1'b1;
				win_idx = 6'(i);
				win_prio = prio[i*LW +: LW];
			end
		end
	end

endmodule

// >>> tb/core_model.sv
// Purpose: Core side that accepts offers and ends services.
// Assumes: Offer stands until acknowledged.
// Notes: lag sets how many offer cycles pass before the ack.
`timescale 1ns/100ps
module core_model (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic svc_valid,
	input wire ivt_pkg::svc_req_t svc_out,
	input wire logic [3:0] lag,
	input wire logic ret_i_req,
	input wire logic ret_t_req,
	output logic svc_ack,
	output logic int_ret,
	output logic trap_ret,
	output ivt_pkg::svc_req_t taken,
	output logic taken_stb
);
	import ivt_pkg::*;
	logic [3:0] wait_r;
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			svc_ack <= 1'b0;
			wait_r <= 4'h0;
			taken_stb <= 1'b0;
			int_ret <= 1'b0;
			trap_ret <= 1'b0;
		end
		else
		begin
			svc_ack <= svc_valid && !svc_ack && wait_r >= lag;
			wait_r <= (svc_valid && !svc_ack) ? wait_r + 4'h1 : 4'h0;
			taken_stb <= svc_ack && svc_valid;
			int_ret <= ret_i_req;
			trap_ret <= ret_t_req;
		end
		if (svc_ack && svc_valid)
			taken <= svc_out;
	end
endmodule

// >>> tb/testbench.sv
// Purpose: Register, vector and trap checks of the unit.
// Assumes: Core model acks offers.
// Notes: Expected vectors are built from the node trap numbers.
`timescale 1ns/100ps
`include "ivt_cfg.svh"
module testbench;
	import ivt_pkg::*;
	logic sys_clk, sys_rst, reg_wr, reg_rd, svc_valid, svc_ack, int_ret, trap_ret;
	logic trap_busy, irq, ret_i_req, ret_t_req, taken_stb;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [50:0] periph_req;
	logic [7:0] trap_evt, seg_v;
	logic [3:0] cpu_level, lag;
	logic [1:0] sp_v;
	svc_req_t svc_out, taken;
	int errors, n_checks, cyc;
	int idx_t[6] = '{27, 28, 0, 5, 15, 50};
	logic [6:0] trp_t[6] = '{7'h5d, 7'h10, 7'h27, 7'h5f, 7'h4c, 7'h58};

	interrupt_vector_and_trap_unit u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .periph_req(periph_req), .trap_evt(trap_evt),
		.svc_out(svc_out), .svc_valid(svc_valid), .svc_ack(svc_ack), .int_ret(int_ret),
		.trap_ret(trap_ret), .cpu_level(cpu_level), .trap_busy(trap_busy), .irq(irq));
	core_model u_core (.sys_clk(sys_clk), .sys_rst(sys_rst), .svc_valid(svc_valid),
		.svc_out(svc_out), .lag(lag), .ret_i_req(ret_i_req), .ret_t_req(ret_t_req),
		.svc_ack(svc_ack), .int_ret(int_ret), .trap_ret(trap_ret), .taken(taken),
		.taken_stb(taken_stb));

	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic final_report;
		if (errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e, "read");
		@(posedge sys_clk);
	endtask

	task automatic pulse(input int i, input logic is_trap);
		if (is_trap)
			trap_evt[i] <= 1'b1;
		else
			periph_req[i] <= 1'b1;
		@(posedge sys_clk);
		trap_evt <= 8'h00;
		periph_req <= '0;
		@(posedge sys_clk);
	endtask

	task automatic ret(input logic t);
		if (t)
			ret_t_req <= 1'b1;
		else
			ret_i_req <= 1'b1;
		@(posedge sys_clk);
		ret_t_req <= 1'b0;
		ret_i_req <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask

	task automatic idle(input int n);
		repeat (n)
		begin
			@(posedge sys_clk);
			#1;
			chk({31'h0, svc_valid}, 32'h0, "offer");
		end
		@(posedge sys_clk);
	endtask

	task automatic take(input logic [6:0] trp, input logic tr);
		int n;
		n = 0;
		while (taken_stb !== 1'b1 && n < 30)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk({31'h0, taken_stb}, 32'h1, "no offer");
		chk({8'h0, taken.vec}, {8'h0, seg_v, 16'({9'h0, trp} << (2 + sp_v))}, "vector");
		chk({24'h0, taken.is_trap, taken.trap}, {24'h0, tr, trp}, "trap number");
		@(posedge sys_clk);
	endtask

	function automatic logic [11:0] nadr(input int i);
		return `NODE_BASE_OFS + 12'(4 * i);
	endfunction

	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			errors++;
			$display("unexpected at %0t: timeout", $time);
			final_report();
		end
	end

	initial
	begin
		{sys_rst, reg_wr, reg_rd, ret_i_req, ret_t_req} = 5'h10;
		{reg_addr, reg_wdata, periph_req, trap_evt, lag} = '0;
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int a = 0; a < 24; a += 4)
			rdc(12'(a), 32'h0);
		wr(12'h018, 32'hffffffff);
		rdc(12'h018, 32'h0);
		for (int k = 0; k < 6; k++)
		begin
			seg_v = 8'h10 + 8'(k);
			sp_v = 2'(k);
			lag <= 4'(k);
			wr(`VEC_SEG_OFS, {24'h0, seg_v});
			wr(`CORE_CFG_OFS, {30'h0, sp_v});
			if (idx_t[k] < 28)
			begin
				wr(nadr(idx_t[k]), 32'h49);
				pulse(idx_t[k], 1'b0);
			end
			else
				wr(nadr(idx_t[k]), 32'hc9);
			take(trp_t[k], 1'b0);
			rdc(`LEVEL_OFS, 32'h9);
			rdc(nadr(idx_t[k]), 32'h49);
			ret(1'b0);
		end
		seg_v = 8'h22;
		sp_v = 2'd0;
		lag <= 4'h0;
		wr(`VEC_SEG_OFS, 32'h22);
		wr(`CORE_CFG_OFS, 32'h0);
		wr(nadr(4), 32'h85);
		idle(6);
		wr(nadr(1), 32'h43);
		wr(nadr(2), 32'h41);
		wr(nadr(3), 32'h45);
		pulse(1, 1'b0);
		take(7'h2a, 1'b0);
		pulse(2, 1'b0);
		idle(6);
		pulse(3, 1'b0);
		take(7'h2b, 1'b0);
		chk({28'h0, cpu_level}, 32'h5, "level");
		ret(1'b0);
		ret(1'b0);
		take(7'h47, 1'b0);
		ret(1'b0);
		wr(nadr(6), 32'h47);
		pulse(4, 1'b1);
		take(7'h0a, 1'b1);
		chk({31'h0, trap_busy}, 32'h1, "busy");
		pulse(6, 1'b0);
		idle(6);
		pulse(1, 1'b1);
		take(7'h04, 1'b1);
		pulse(5, 1'b1);
		idle(6);
		rdc(`TRAP_FLAG_OFS, 32'h32);
		wr(`TRAP_FLAG_OFS, 32'h32);
		rdc(`TRAP_FLAG_OFS, 32'h0);
		ret(1'b1);
		idle(4);
		ret(1'b1);
		take(7'h0a, 1'b1);
		ret(1'b1);
		take(7'h2d, 1'b0);
		ret(1'b0);
		rdc(`IRQ_STAT_OFS, 32'h3);
		chk({31'h0, irq}, 32'h0, "irq");
		wr(`IRQ_MASK_OFS, 32'h2);
		chk({31'h0, irq}, 32'h1, "irq");
		wr(`IRQ_STAT_OFS, 32'h2);
		chk({31'h0, irq}, 32'h0, "irq");
		rdc(`IRQ_STAT_OFS, 32'h1);
		final_report();
	end
endmodule
